// ===== verilog/bmts_map.svh
// register offsets, field positions and reset values of the trigger sequencer
// assumes byte addresses on a 32-bit apb bus, one word per register
`ifndef BMTS_MAP_SVH
`define BMTS_MAP_SVH

// global registers
`define BMTS_OFF_CTRL       12'h000
`define BMTS_OFF_FTW        12'h004
`define BMTS_OFF_STOP_MASK  12'h008
`define BMTS_OFF_STATUS     12'h00C
`define BMTS_OFF_IRQ_STAT   12'h010
`define BMTS_OFF_IRQ_MASK   12'h014
// trigger control blocks: base + index*16 + word*4
`define BMTS_OFF_TCB_BASE   12'h100

// control register fields
`define BMTS_CTRL_RUN       0
`define BMTS_CTRL_STD_MODE  1
`define BMTS_CTRL_FIRST_LSB 8
`define BMTS_CTRL_RESET     32'h0000_0000

// capture event trigger word fields
`define BMTS_FTW_SCMP_LSB   0
`define BMTS_FTW_SMASK_LSB  8
`define BMTS_FTW_PCMP_LSB   16
`define BMTS_FTW_RESET      32'h0000_0000
`define BMTS_STOP_MASK_RST  8'h00

// tcb word 0 fields
`define BMTS_TCB_KIND_LSB   0
`define BMTS_TCB_SOT        2
`define BMTS_TCB_TRI        3
`define BMTS_TCB_INV        4
`define BMTS_TCB_POS_LSB    8
// tcb word 1 fields
`define BMTS_TCB_TRES_LSB   0
`define BMTS_TCB_TSET_LSB   8
`define BMTS_TCB_NEXT_LSB   16
`define BMTS_TCB_EOM_LSB    24
// tcb word 2 fields
`define BMTS_TCB_TDW_LSB    0
`define BMTS_TCB_TMW_LSB    16
// tcb word 3 fields
`define BMTS_TCB_LLI_LSB    0
`define BMTS_TCB_ULI_LSB    16

// interrupt status bits
`define BMTS_IRQ_TRIG       0
`define BMTS_IRQ_START      1
`define BMTS_IRQ_STOP       2

// data word positions within a transfer
`define BMTS_POS_MIN        6'h01
`define BMTS_POS_MAX        6'h20

`endif

// ===== verilog/bmts_pkg.sv
// types shared by the trigger sequencer modules
// assumes the constants of bmts_map.svh
package bmts_pkg;

  typedef enum logic [1:0] {
    BMTS_KIND_ERROR,
    BMTS_KIND_EXTERNAL,
    BMTS_KIND_RX_WORD,
    BMTS_KIND_DATA_VALUE
  } bmts_kind_e;

  typedef logic [7:0]  bmts_pattern_t;
  typedef logic [15:0] bmts_word_t;

endpackage : bmts_pkg

// ===== verilog/bmts_eval_if.sv
// carrier between the sequencer and its data value evaluator
// assumes a single clock domain; the evaluator is combinational
`timescale 1ns/1ps
interface bmts_eval_if;
  logic                  valid;
  bmts_pkg::bmts_word_t  word;
  logic [5:0]            position;
  bmts_pkg::bmts_kind_e  kind;
  logic                  inv;
  logic [5:0]            tsp;
  bmts_pkg::bmts_word_t  tmw;
  bmts_pkg::bmts_word_t  tlli;
  bmts_pkg::bmts_word_t  tuli;
  logic                  in_range;
  logic                  hit;

  modport seq  (output valid, word, position, kind, inv, tsp, tmw, tlli,
                tuli, input in_range, hit);
  modport eval (input valid, word, position, kind, inv, tsp, tmw, tlli,
                tuli, output in_range, hit);
endinterface : bmts_eval_if

// ===== verilog/bmts_eval.sv
// data value condition of the armed trigger control block
// assumes the sequencer qualifies valid with a data word and the run bit
`timescale 1ns/1ps
`include "bmts_map.svh"
module bmts_eval (
  // evaluation request and answer
  bmts_eval_if.eval e
);
  bmts_pkg::bmts_word_t masked;
  logic                 pos_ok;

  assign masked = e.word & e.tmw;
  assign e.in_range = (masked >= e.tlli) && (masked <= e.tuli);
  // positions outside 1..32 never match a data word
  assign pos_ok = (e.position == e.tsp) && (e.tsp >= `BMTS_POS_MIN) &&
                  (e.tsp <= `BMTS_POS_MAX);
  // other kinds are not evaluated anywhere; here they never fire
  assign e.hit = e.valid && pos_ok &&
                 (e.kind == bmts_pkg::BMTS_KIND_DATA_VALUE) &&
                 (e.in_range ^ e.inv);
endmodule : bmts_eval

// ===== verilog/bmts_seq.sv
// trigger sequencer of the bus monitor: tcb store, pattern, capture events
// assumes word strobes come from the bus interface processor on pclk
`timescale 1ns/1ps
`include "bmts_map.svh"
// Behaviour
// - Every block holds a kind code: 0 error, 1 external, 2 word, 3 data.
// - A data value check first ANDs the bus word with the block's mask.
// - The check holds when the masked word lies within lower..upper.
// - With invert set, the opposite of the limit check is the condition.
// - The block's specification field picks the data word position.
// - Valid positions run from 1 to 32, matching data words 1 to 32.
// - On a hit the reset mask bits clear and the set mask bits set.
// - On a hit the block named by the next field becomes armed.
// - At message end without a hit the eom block is armed, pattern kept.
// - A hit with the strobe option pulses the external trigger strobe.
// - A hit with the interrupt option raises the trigger interrupt.
// - Start fires on pattern&start mask==start compare, stop likewise.
// - Stop mask and compare count only in standard capture mode.
// - The trigger word holds start compare, start mask, stop compare.
module bmts_seq #(
  parameter int NUM_TCB = 16
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // monitored bus words
  input  wire logic        mon_word_valid,
  input  wire logic        mon_word_is_data,
  input  wire logic [15:0] mon_word,
  input  wire logic        mon_eom,
  // outputs
  output logic             trig_strobe,
  output logic             capture_active,
  output logic             irq
);
  localparam int IW = $clog2(NUM_TCB);

  logic [31:0] tcb_q [NUM_TCB][4];
  logic [31:0] ctrl_q, ftw_q;
  logic [7:0]  stop_mask_q, pattern_q, pattern_d;
  logic [2:0]  irq_stat_q, irq_mask_q, irq_set;
  logic [IW-1:0] armed_q;
  logic [5:0]  pos_q;
  logic        ready_q, slverr_q, strobe_q, capture_q, irq_q;
  logic [31:0] rdata_q, rd_d;
  logic        map_ok, wr_en, setup;
  logic        tcb_sel, tcb_hit, start_hit, stop_hit, run, std_mode;
  logic [IW-1:0] tcb_idx;
  logic [31:0] w0, w1, w2, w3;

  bmts_eval_if ev ();

  bmts_eval u_eval (
    .e (ev)
  );

  assign run      = ctrl_q[`BMTS_CTRL_RUN];
  assign std_mode = ctrl_q[`BMTS_CTRL_STD_MODE];
  assign w0 = tcb_q[armed_q][0];
  assign w1 = tcb_q[armed_q][1];
  assign w2 = tcb_q[armed_q][2];
  assign w3 = tcb_q[armed_q][3];

  // armed block feeds the evaluator
  assign ev.valid    = run && mon_word_valid && mon_word_is_data;
  assign ev.word     = mon_word;
  assign ev.position = pos_q + 6'h01;
  assign ev.kind     = bmts_pkg::bmts_kind_e'(w0[`BMTS_TCB_KIND_LSB +: 2]);
  assign ev.inv      = w0[`BMTS_TCB_INV];
  assign ev.tsp      = w0[`BMTS_TCB_POS_LSB +: 6];
  assign ev.tmw      = w2[`BMTS_TCB_TMW_LSB +: 16];
  assign ev.tlli     = w3[`BMTS_TCB_LLI_LSB +: 16];
  assign ev.tuli     = w3[`BMTS_TCB_ULI_LSB +: 16];
  assign tcb_hit     = ev.hit;

  assign pattern_d = (pattern_q & ~w1[`BMTS_TCB_TRES_LSB +: 8]) |
                     w1[`BMTS_TCB_TSET_LSB +: 8];
  // checked against the pattern being written, so chained sets count
  assign start_hit = tcb_hit && !capture_q &&
                     ((pattern_d & ftw_q[`BMTS_FTW_SMASK_LSB +: 8]) ==
                      ftw_q[`BMTS_FTW_SCMP_LSB +: 8]);
  assign stop_hit  = tcb_hit && capture_q && std_mode &&
                     ((pattern_d & stop_mask_q) ==
                      ftw_q[`BMTS_FTW_PCMP_LSB +: 8]);

  // apb decode; answer one cycle after setup, no wait states
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && ready_q && pwrite && !slverr_q;
  assign tcb_sel = (paddr >= `BMTS_OFF_TCB_BASE) &&
                   ({4'h0, paddr[11:4]} < 12'(NUM_TCB + 16));
  assign tcb_idx = paddr[4 +: IW];

  always_comb begin
    map_ok = 1'b1;
    rd_d   = 32'h0000_0000;
    if (tcb_sel && paddr[1:0] == 2'h0) begin
      rd_d = tcb_q[tcb_idx][paddr[3:2]];
    end else begin
      case (paddr)
        `BMTS_OFF_CTRL:      rd_d = ctrl_q;
        `BMTS_OFF_FTW:       rd_d = ftw_q;
        `BMTS_OFF_STOP_MASK: rd_d = {24'h00_0000, stop_mask_q};
        `BMTS_OFF_STATUS:    rd_d = {15'h0000, capture_q,
                                     8'(armed_q), pattern_q};
        `BMTS_OFF_IRQ_STAT:  rd_d = {29'h0000_0000, irq_stat_q};
        `BMTS_OFF_IRQ_MASK:  rd_d = {29'h0000_0000, irq_mask_q};
        default:             map_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ready_q  <= setup;
      slverr_q <= setup && !map_ok;
      rdata_q  <= (setup && !pwrite && map_ok) ? rd_d : 32'h0000_0000;
    end
  end

  // software configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `BMTS_CTRL_RESET;
      ftw_q       <= `BMTS_FTW_RESET;
      stop_mask_q <= `BMTS_STOP_MASK_RST;
      irq_mask_q  <= 3'h0;
    end else if (wr_en) begin
      case (paddr)
        `BMTS_OFF_CTRL:      ctrl_q      <= pwdata;
        `BMTS_OFF_FTW:       ftw_q       <= pwdata;
        `BMTS_OFF_STOP_MASK: stop_mask_q <= pwdata[7:0];
        `BMTS_OFF_IRQ_MASK:  irq_mask_q  <= pwdata[2:0];
        default:             ;
      endcase
    end
  end

  // block store; no reset loop cost beyond flops, kept small by NUM_TCB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_TCB; i++) begin
        for (int j = 0; j < 4; j++) begin
          tcb_q[i][j] <= 32'h0000_0000;
        end
      end
    end else if (wr_en && tcb_sel) begin
      tcb_q[tcb_idx][paddr[3:2]] <= pwdata;
    end
  end

  // data word position within the current message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= 6'h00;
    end else if (mon_eom) begin
      pos_q <= 6'h00;
    end else if (mon_word_valid && mon_word_is_data &&
                 pos_q != 6'h3F) begin
      pos_q <= pos_q + 6'h01;
    end
  end

  // arming and pattern; a hit outranks a simultaneous message end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q   <= '0;
      pattern_q <= 8'h00;
    end else if (!run) begin
      armed_q   <= ctrl_q[`BMTS_CTRL_FIRST_LSB +: IW];
    end else if (tcb_hit) begin
      pattern_q <= pattern_d;
      armed_q   <= w1[`BMTS_TCB_NEXT_LSB +: IW];
    end else if (mon_eom) begin
      armed_q   <= w1[`BMTS_TCB_EOM_LSB +: IW];
    end
  end

  // capture state and strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= 1'b0;
      strobe_q  <= 1'b0;
    end else begin
      strobe_q <= tcb_hit && w0[`BMTS_TCB_SOT];
      if (start_hit) begin
        capture_q <= 1'b1;
      end else if (stop_hit || !run) begin
        capture_q <= 1'b0;
      end
    end
  end

  // sticky interrupt causes; a new event wins over a write-one clear
  assign irq_set = {stop_hit, start_hit, tcb_hit && w0[`BMTS_TCB_TRI]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
      if (wr_en && paddr == `BMTS_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end

  assign pready         = ready_q;
  assign prdata         = rdata_q;
  assign pslverr        = slverr_q;
  assign trig_strobe    = strobe_q;
  assign capture_active = capture_q;
  assign irq            = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_kind;
    tcb_hit |-> ev.kind == bmts_pkg::BMTS_KIND_DATA_VALUE;
  endproperty
  a_kind: assert property (p_kind) else $error("hit on non data kind");

  property p_range;
    tcb_hit && !ev.inv |-> ((mon_word & ev.tmw) >= ev.tlli) &&
                           ((mon_word & ev.tmw) <= ev.tuli);
  endproperty
  a_range: assert property (p_range) else $error("hit out of limits");

  property p_inv;
    tcb_hit && ev.inv |-> !(((mon_word & ev.tmw) >= ev.tlli) &&
                            ((mon_word & ev.tmw) <= ev.tuli));
  endproperty
  a_inv: assert property (p_inv) else $error("inverted hit in range");

  property p_pos;
    tcb_hit |-> ev.tsp == pos_q + 6'h01 && ev.tsp >= 6'h01 &&
                ev.tsp <= 6'h20;
  endproperty
  a_pos: assert property (p_pos) else $error("hit at wrong position");

  property p_pattern;
    tcb_hit |=> pattern_q == (($past(pattern_q) & ~$past(w1[7:0])) |
                              $past(w1[15:8]));
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern wrong");

  property p_next;
    tcb_hit |=> armed_q == $past(w1[16 +: IW]);
  endproperty
  a_next: assert property (p_next) else $error("next block not armed");

  property p_eom;
    run && mon_eom && !tcb_hit |=> armed_q == $past(w1[24 +: IW]) &&
                                   $stable(pattern_q);
  endproperty
  a_eom: assert property (p_eom) else $error("eom arming wrong");

  property p_strobe;
    tcb_hit && w0[2] |=> trig_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe missing");

  sequence s_trig_irq;
    tcb_hit && w0[3] && irq_mask_q[0];
  endsequence
  sequence s_irq_up;
    irq_stat_q[0] ##1 irq;
  endsequence
  property p_irq;
    s_trig_irq |=> s_irq_up;
  endproperty
  a_irq: assert property (p_irq) else $error("trigger irq missing");

  property p_start;
    tcb_hit && !capture_q &&
    ((pattern_d & ftw_q[15:8]) == ftw_q[7:0]) |=> capture_q;
  endproperty
  a_start: assert property (p_start) else $error("capture not started");

  property p_stop_std;
    capture_q && run && !std_mode && !start_hit |=> capture_q;
  endproperty
  a_stop_std: assert property (p_stop_std) else $error("stop outside std");

endmodule : bmts_seq

// ===== tb/bmts_bus_src.sv
// model of the monitored bus: command and data words, message ends
// assumes the tasks are called just after a rising edge of pclk
`timescale 1ns/1ps
module bmts_bus_src (
  // clock
  input  wire logic        pclk,
  // word stream toward the sequencer
  output logic             mon_word_valid,
  output logic             mon_word_is_data,
  output logic [15:0]      mon_word,
  output logic             mon_eom
);
  initial begin
    mon_word_valid = 1'b0;
    mon_word_is_data = 1'b0;
    mon_word = 16'h0000;
    mon_eom = 1'b0;
  end

  // idle cycles model a slow bus; zero keeps valid high back to back
  task automatic word(input logic d, input logic [15:0] v, input int idle);
    mon_word_valid   <= 1'b1;
    mon_word_is_data <= d;
    mon_word         <= v;
    @(posedge pclk);
    if (idle > 0) begin
      mon_word_valid   <= 1'b0;
      // no pull on the word lines: show garbage, not the last word
      mon_word         <= ~v;
      mon_word_is_data <= ~d;
      repeat (idle) @(posedge pclk);
    end
  endtask : word

  task automatic eom();
    mon_word_valid <= 1'b0;
    mon_word       <= ~mon_word;
    mon_eom        <= 1'b1;
    @(posedge pclk);
    mon_eom        <= 1'b0;
  endtask : eom
endmodule : bmts_bus_src

// ===== tb/bmts_seq_test.sv
// self-checking bench of the trigger sequencer through its apb port
// assumes bmts_bus_src drives the monitored words on the same clock
`timescale 1ns/1ps
`include "bmts_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module bmts_seq_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mon_word_valid, mon_word_is_data, mon_eom;
  logic [15:0] mon_word;
  logic        trig_strobe, capture_active, irq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          strobe_cnt = 0;
  logic [11:0] offs [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                            12'h014};
  // block 0 window, 1 inverted, 2 clears pattern, 3 external kind
  logic [31:0] cfg [16] = '{
    32'h0000_020F, 32'h0301_0100, 32'h00FF_0000, 32'h0020_0010,
    32'h0000_0113, 32'h0102_0E01, 32'hFFFF_0000, 32'h0007_0000,
    32'h0000_0103, 32'h0200_000F, 32'hFFFF_0000, 32'hFFFF_0000,
    32'h0000_0101, 32'h0000_FF00, 32'hFFFF_0000, 32'hFFFF_0000};

  bmts_seq #(.NUM_TCB(16)) bmts_seq_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mon_word_valid(mon_word_valid), .mon_word_is_data(mon_word_is_data),
    .mon_word(mon_word), .mon_eom(mon_eom), .trig_strobe(trig_strobe),
    .capture_active(capture_active), .irq(irq));
  bmts_bus_src bmts_bus_src_inst (.pclk(pclk),
    .mon_word_valid(mon_word_valid), .mon_word_is_data(mon_word_is_data),
    .mon_word(mon_word), .mon_eom(mon_eom));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (trig_strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // one transfer plus an idle cycle, so psel is never set twice at an edge
  // no cycle limit here: only the watchdog ends a wait for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
    `CHK(er, 1'b0)
  endtask : rchk

  // whole trigger chain; std gives the capture mode already set in the control register, for the expected results
  task automatic flow(input logic std);
    int s0;
    s0 = strobe_cnt;
    bmts_bus_src_inst.word(1'b1, 16'h1234, 0);
    bmts_bus_src_inst.word(1'b1, 16'h000F, 2);
    bmts_bus_src_inst.eom();
    rchk(`BMTS_OFF_STATUS, 32'h0000_0300);
    bmts_bus_src_inst.word(1'b1, 16'h0033, 0);
    bmts_bus_src_inst.eom();
    rchk(`BMTS_OFF_STATUS, 32'h0000_0000);
    bmts_bus_src_inst.word(1'b0, 16'h0C20, 0);
    bmts_bus_src_inst.word(1'b1, 16'hFF00, 0);
    bmts_bus_src_inst.word(1'b1, 16'hAB10, 0);
    bmts_bus_src_inst.eom();
    rchk(`BMTS_OFF_STATUS, 32'h0000_0101);
    `CHK(irq, 1'b1)
    rchk(`BMTS_OFF_IRQ_STAT, 32'h0000_0001);
    wr(`BMTS_OFF_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    bmts_bus_src_inst.word(1'b1, 16'h0007, 1);
    bmts_bus_src_inst.eom();
    rchk(`BMTS_OFF_STATUS, 32'h0000_0101);
    bmts_bus_src_inst.word(1'b1, 16'h0008, 0);
    bmts_bus_src_inst.eom();
    rchk(`BMTS_OFF_STATUS, 32'h0001_020E);
    `CHK(capture_active, 1'b1)
    `CHK(strobe_cnt, s0 + 1)
    `CHK(irq, 1'b0)
    bmts_bus_src_inst.word(1'b1, 16'h5555, 0);
    bmts_bus_src_inst.eom();
    // block 0 armed by the hit, then its eom choice (3) at message end
    rchk(`BMTS_OFF_STATUS, {15'h0000, ~std, 8'h03, 8'h00});
    `CHK(capture_active, ~std)
    rchk(`BMTS_OFF_IRQ_STAT, {29'h0, std, 2'b10});
    wr(`BMTS_OFF_IRQ_STAT, 32'h0000_0007);
  endtask : flow

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rchk(offs[i], 32'h0000_0000);
    `CHK(irq, 1'b0)
    `CHK(capture_active, 1'b0)
    // unmapped and misaligned places are refused
    apb(1'b0, 12'h018, 32'h0000_0000);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0000_0000)
    wr(12'h005, 32'hFFFF_FFFF);
    `CHK(er, 1'b1)
    rchk(`BMTS_OFF_FTW, 32'h0000_0000);
    for (int i = 0; i < 16; i++) wr(`BMTS_OFF_TCB_BASE + 12'(4 * i), cfg[i]);
    rchk(`BMTS_OFF_TCB_BASE, cfg[0]);
    wr(`BMTS_OFF_FTW, 32'h0000_0F0E);
    rchk(`BMTS_OFF_FTW, 32'h0000_0F0E);
    wr(`BMTS_OFF_STOP_MASK, 32'h0000_000F);
    rchk(`BMTS_OFF_STOP_MASK, 32'h0000_000F);
    wr(`BMTS_OFF_IRQ_MASK, 32'h0000_0001);
    wr(`BMTS_OFF_CTRL, 32'h0000_0003);
    flow(1'b1);
    wr(`BMTS_OFF_CTRL, 32'h0000_0000);
    wr(`BMTS_OFF_CTRL, 32'h0000_0001);
    flow(1'b0);
    close_out();
  end

  // the tests take well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
endmodule : bmts_seq_test
